// file: design/rcs_pkg.sv
/*
  shared constants for the reference clock switchover block: register offsets,
  field positions, reset values and detector counts.
  assumes byte offsets on an 8-bit address, 32-bit data.
*/
package rcs_pkg;

  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int NUM_LOOPS = 4;

  // register offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_CRYSTAL_LOAD_TRIM = 8'h04;
  localparam logic [7:0] OFS_LOOP0 = 8'h08;
  localparam logic [7:0] OFS_STATUS = 8'h18;
  localparam logic [7:0] OFS_LOADCAP = 8'h1C;
  localparam logic [7:0] OFS_MULT0 = 8'h20;
  localparam logic [7:0] OFS_STRIDE = 8'h04;

  // control fields
  localparam int CTRL_PRIM_BIT = 0;
  localparam int CTRL_MODE_LSB = 1;
  localparam int CTRL_MODE_MSB = 2;

  // crystal fields
  localparam int CRYSTAL_LOAD_TRIM_TRIM_LSB = 0;
  localparam int CRYSTAL_LOAD_TRIM_TRIM_MSB = 4;
  localparam int CRYSTAL_LOAD_TRIM_DRV_LSB = 8;
  localparam int CRYSTAL_LOAD_TRIM_DRV_MSB = 9;

  // loop fields
  localparam int LOOP_DIV_LSB = 0;
  localparam int LOOP_DIV_MSB = 6;
  localparam int LOOP_CNT_LSB = 8;
  localparam int LOOP_CNT_MSB = 19;
  localparam int LOOP_ADD_LSB = 24;
  localparam int LOOP_ADD_MSB = 27;

  // status fields
  localparam int ST_SECONDARY_BIT = 0;
  localparam int ST_LOST_BIT = 1;
  localparam int ST_PWRDN_LSB = 2;
  localparam int ST_ERR_LSB = 6;
  localparam int ST_AUTO_BIT = 10;

  // reset values
  localparam logic PRIM_RST = 1'b0;
  localparam logic [1:0] MODE_RST = 2'h0;
  localparam logic [4:0] TRIM_RST = 5'h00;
  localparam logic [1:0] DRV_RST = 2'h3;
  localparam logic [6:0] DIV_RST = 7'h01;
  localparam logic [11:0] CNT_RST = 12'h010;
  localparam logic [3:0] ADD_RST = 4'h0;

  // load capacitance in eighths of a pF: 3.5 pF base, 0.125 pF step
  localparam logic [5:0] LOAD_BASE_EIGHTHS = 6'h1C;

  // lowest legal pre-divider of the fourth loop
  localparam logic [6:0] LOOP3_DIV_MIN = 7'h03;

  // silent secondary cycles that declare the primary lost
  localparam logic [1:0] LOSS_CYCLES = 2'h2;

  typedef enum logic [1:0] {
    ST_FOLLOW = 2'b00,
    ST_PARK = 2'b01,
    ST_WAIT_NEW = 2'b10
  } rcs_mux_state_t;

endpackage

// file: design/rcs_pin_sync.sv
/*
  three-stage synchroniser with agreement filter for asynchronous pins.
  assumes inputs are unrelated to clk; output updates when stages two and
  three agree.
*/
`timescale 1ns/1ps
module rcs_pin_sync #(
  parameter int WIDTH = 3
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [WIDTH-1:0] pinIn,
  output logic [WIDTH-1:0] pinOut
);

  logic [WIDTH-1:0] stage1_q;
  logic [WIDTH-1:0] stage2_q;
  logic [WIDTH-1:0] stage3_q;
  logic [WIDTH-1:0] out_q;
  logic [WIDTH-1:0] out_d;

  genvar g;
  generate
    for (g = 0; g < WIDTH; g++)
    begin : gen_bit
      assign out_d[g] = (stage2_q[g] == stage3_q[g]) ? stage3_q[g] : out_q[g];
    end
  endgenerate

  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      stage1_q <= '0;
      stage2_q <= '0;
      stage3_q <= '0;
      out_q <= '0;
    end
    else
    begin
      stage1_q <= pinIn;
      stage2_q <= stage1_q;
      stage3_q <= stage2_q;
      out_q <= out_d;
    end
  end

  assign pinOut = out_q;

endmodule

// file: design/rcs_ref_clock_switchover.sv
/*
  reference clock selection: register port, manual and automatic revertive
  switchover with glitch-free hand-over, loss detection of the primary
  clock, loop divider checks and crystal trim settings.
  assumes both reference inputs are far slower than clk so their levels can
  be sampled; the selected reference leaves as a registered level.
*/
// Added by the designer: the address map and the strobed register port.
`timescale 1ns/1ps
module rcs_ref_clock_switchover #(
  parameter logic [6:0] DIV_RESET = rcs_pkg::DIV_RST,
  parameter logic [11:0] CNT_RESET = rcs_pkg::CNT_RST
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [7:0] regAddr,
  input wire logic [31:0] regWdata,
  input wire logic regWrite,
  input wire logic regRead,
  output logic [31:0] regRdata,
  input wire logic crystal_or_ref_input,
  input wire logic aux_clock_input,
  input wire logic input_select_pin,
  output logic refClkOut,
  output logic activeSecondary,
  output logic [3:0] loopPowerDown,
  output logic [4:0] crystal_load_trim,
  output logic [1:0] crystal_drive_strength
);

  // setting checks called for every loop; only loops 0 and 3 have a rule, loops 1 and 2 are never flagged
  function automatic logic loopBad(input int idx, input logic [6:0] dv,
                                   input logic [11:0] cnt, input logic [3:0] add);
    logic bad;
    bad = 1'b0;
    if (idx == 3 && dv < rcs_pkg::LOOP3_DIV_MIN)
      bad = 1'b1;
    if (idx == 0 && add != 4'h0 && {8'h00, add} > (cnt - 12'h001))
      bad = 1'b1;
    return bad;
  endfunction

  logic primarySel_q;
  logic [1:0] switchMode_q;
  logic [4:0] trim_q;
  logic [1:0] drive_q;
  logic [6:0] div_q [rcs_pkg::NUM_LOOPS];
  logic [11:0] cnt_q [rcs_pkg::NUM_LOOPS];
  logic [3:0] add_q;
  logic [13:0] mult_q [rcs_pkg::NUM_LOOPS];
  logic [3:0] pwrDn_q;
  logic [3:0] err_q;
  logic [5:0] loadCap_q;
  logic [31:0] rdata_q;

  logic [2:0] pinSync;
  logic refS;
  logic auxS;
  logic selS;
  logic priPrev_q;
  logic secPrev_q;
  logic [1:0] lossCnt_q;
  logic [1:0] lossCnt_d;
  logic primaryLost_q;
  logic primaryLost_d;

  rcs_pkg::rcs_mux_state_t state_q;
  rcs_pkg::rcs_mux_state_t state_d;
  logic curAux_q;
  logic curAux_d;
  logic out_q;
  logic out_d;

  rcs_pin_sync #(
    .WIDTH(3)
  ) u_pin_sync (
    .clk(clk),
    .reset_n(reset_n),
    .pinIn({input_select_pin, aux_clock_input, crystal_or_ref_input}),
    .pinOut(pinSync)
  );

  assign refS = pinSync[0];
  assign auxS = pinSync[1];
  assign selS = pinSync[2];

  // address decode
  wire wrCtrl = regWrite && regAddr == rcs_pkg::OFS_CTRL;
  wire wrXtal = regWrite && regAddr == rcs_pkg::OFS_CRYSTAL_LOAD_TRIM;
  wire autoMode = switchMode_q[1];

  // primary and secondary levels follow the primary-source bit
  wire priLevel = primarySel_q ? auxS : refS;
  wire secLevel = primarySel_q ? refS : auxS;
  wire priEdge = priLevel != priPrev_q;
  wire secRise = secLevel && !secPrev_q;

  // loss detector counts secondary rising edges since the last primary edge
  wire lossReached = secRise && (lossCnt_q == rcs_pkg::LOSS_CYCLES - 2'h1);

  always_comb
  begin
    lossCnt_d = lossCnt_q;
    primaryLost_d = primaryLost_q;
    if (!autoMode)
    begin
      lossCnt_d = 2'h0;
      primaryLost_d = 1'b0;
    end
    else if (priEdge)
    begin
      lossCnt_d = 2'h0;
      primaryLost_d = 1'b0;
    end
    else if (secRise && lossCnt_q != rcs_pkg::LOSS_CYCLES)
    begin
      lossCnt_d = lossCnt_q + 2'h1;
      if (lossReached)
        primaryLost_d = 1'b1;
    end
  end

  // wanted physical source: manual by pin, automatic by loss state
  wire wantSecondary = autoMode ? primaryLost_q : selS;
  wire targetAux = primarySel_q ^ wantSecondary;
  wire curLevel = curAux_q ? auxS : refS;
  wire newLevel = targetAux ? auxS : refS;

  // break before make: the old source is let go only while low, and the
  // new one is taken only from a low level, so no runt pulse leaves.
  // a dead new source holds the output low until it starts toggling.
  always_comb
  begin
    state_d = state_q;
    curAux_d = curAux_q;
    out_d = out_q;
    case (state_q)
      rcs_pkg::ST_FOLLOW:
      begin
        out_d = curLevel;
        if (targetAux != curAux_q)
          state_d = rcs_pkg::ST_PARK;
      end
      rcs_pkg::ST_PARK:
      begin
        out_d = out_q & curLevel;
        if (!curLevel)
        begin
          out_d = 1'b0;
          curAux_d = targetAux;
          state_d = rcs_pkg::ST_WAIT_NEW;
        end
      end
      rcs_pkg::ST_WAIT_NEW:
      begin
        out_d = 1'b0;
        if (!curLevel)
          state_d = rcs_pkg::ST_FOLLOW;
      end
      default:
      begin
        state_d = rcs_pkg::ST_FOLLOW;
        out_d = 1'b0;
      end
    endcase
  end

  // loop registers, multiplier and check logic per loop
  logic [13:0] multCalc [rcs_pkg::NUM_LOOPS];
  logic [3:0] errCalc;
  logic [3:0] pwrCalc;
  logic [31:0] loopWord [rcs_pkg::NUM_LOOPS];
  logic [31:0] multWord [rcs_pkg::NUM_LOOPS];
  logic [3:0] rdLoopHit;
  logic [3:0] rdMultHit;

  genvar i;
  generate
    for (i = 0; i < rcs_pkg::NUM_LOOPS; i++)
    begin : gen_loop
      localparam logic [7:0] LOOP_OFS = rcs_pkg::OFS_LOOP0 + 8'(i) * rcs_pkg::OFS_STRIDE;
      localparam logic [7:0] MULT_OFS = rcs_pkg::OFS_MULT0 + 8'(i) * rcs_pkg::OFS_STRIDE;
      wire wrLoop = regWrite && regAddr == LOOP_OFS;
      assign rdLoopHit[i] = regAddr == LOOP_OFS;
      assign rdMultHit[i] = regAddr == MULT_OFS;
      if (i == 0)
      begin : gen_frac
        // first loop doubles the count and folds in the fractional add
        assign multCalc[i] = (add_q != 4'h0) ?
          14'({1'b0, cnt_q[i], 1'b0} + {10'h000, add_q} + 14'h0001) :
          {1'b0, cnt_q[i], 1'b0};
        assign loopWord[i] = {4'h0, add_q, 4'h0, cnt_q[i], 1'b0, div_q[i]};
      end
      else
      begin : gen_int
        assign multCalc[i] = {2'h0, cnt_q[i]};
        assign loopWord[i] = {12'h000, cnt_q[i], 1'b0, div_q[i]};
      end
      assign errCalc[i] = loopBad(i, div_q[i], cnt_q[i], add_q);
      assign pwrCalc[i] = (i != 3) && (div_q[i] == 7'h00);
      assign multWord[i] = {18'h0_0000, mult_q[i]};

      always_ff @(posedge clk)
      begin
        if (!reset_n)
        begin
          div_q[i] <= DIV_RESET;
          cnt_q[i] <= CNT_RESET;
          mult_q[i] <= 14'h0000;
        end
        else
        begin
          if (wrLoop)
          begin
            div_q[i] <= regWdata[rcs_pkg::LOOP_DIV_MSB:rcs_pkg::LOOP_DIV_LSB];
            cnt_q[i] <= regWdata[rcs_pkg::LOOP_CNT_MSB:rcs_pkg::LOOP_CNT_LSB];
          end
          mult_q[i] <= multCalc[i];
        end
      end
    end
  endgenerate

  wire wrLoop0 = regWrite && regAddr == rcs_pkg::OFS_LOOP0;

  // read data assembly
  wire [31:0] ctrlWord = {29'h0000_0000, switchMode_q, primarySel_q};
  wire [31:0] xtalWord = {22'h00_0000, drive_q, 3'h0, trim_q};
  wire [31:0] statusWord = {21'h00_0000, autoMode, err_q, pwrDn_q, primaryLost_q,
                            activeSecondary};
  wire [31:0] loadWord = {26'h000_0000, loadCap_q};

  logic [31:0] readMux;
  always_comb
  begin
    readMux = 32'h0000_0000;
    case (regAddr)
      rcs_pkg::OFS_CTRL: readMux = ctrlWord;
      rcs_pkg::OFS_CRYSTAL_LOAD_TRIM: readMux = xtalWord;
      rcs_pkg::OFS_STATUS: readMux = statusWord;
      rcs_pkg::OFS_LOADCAP: readMux = loadWord;
      default:
      begin
        for (int k = 0; k < rcs_pkg::NUM_LOOPS; k++)
        begin
          if (rdLoopHit[k])
            readMux = loopWord[k];
          if (rdMultHit[k])
            readMux = multWord[k];
        end
      end
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      primarySel_q <= rcs_pkg::PRIM_RST;
      switchMode_q <= rcs_pkg::MODE_RST;
      trim_q <= rcs_pkg::TRIM_RST;
      drive_q <= rcs_pkg::DRV_RST;
      add_q <= rcs_pkg::ADD_RST;
      loadCap_q <= rcs_pkg::LOAD_BASE_EIGHTHS;
      pwrDn_q <= 4'h0;
      err_q <= 4'h0;
      rdata_q <= 32'h0000_0000;
    end
    else
    begin
      if (wrCtrl)
      begin
        primarySel_q <= regWdata[rcs_pkg::CTRL_PRIM_BIT];
        switchMode_q <= regWdata[rcs_pkg::CTRL_MODE_MSB:rcs_pkg::CTRL_MODE_LSB];
      end
      if (wrXtal)
      begin
        trim_q <= regWdata[rcs_pkg::CRYSTAL_LOAD_TRIM_TRIM_MSB:rcs_pkg::CRYSTAL_LOAD_TRIM_TRIM_LSB];
        drive_q <= regWdata[rcs_pkg::CRYSTAL_LOAD_TRIM_DRV_MSB:rcs_pkg::CRYSTAL_LOAD_TRIM_DRV_LSB];
      end
      if (wrLoop0)
        add_q <= regWdata[rcs_pkg::LOOP_ADD_MSB:rcs_pkg::LOOP_ADD_LSB];
      loadCap_q <= rcs_pkg::LOAD_BASE_EIGHTHS + {1'b0, trim_q};
      pwrDn_q <= pwrCalc;
      err_q <= errCalc;
      rdata_q <= regRead ? readMux : 32'h0000_0000;
    end
  end

  // the switch acts on sampled levels, unrelated to either reference
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      priPrev_q <= 1'b0;
      secPrev_q <= 1'b0;
      lossCnt_q <= 2'h0;
      primaryLost_q <= 1'b0;
      state_q <= rcs_pkg::ST_FOLLOW;
      curAux_q <= 1'b0;
      out_q <= 1'b0;
      activeSecondary <= 1'b0;
    end
    else
    begin
      priPrev_q <= priLevel;
      secPrev_q <= secLevel;
      lossCnt_q <= lossCnt_d;
      primaryLost_q <= primaryLost_d;
      state_q <= state_d;
      curAux_q <= curAux_d;
      out_q <= out_d;
      activeSecondary <= curAux_d != primarySel_q;
    end
  end

  assign regRdata = rdata_q;
  assign refClkOut = out_q;
  assign loopPowerDown = pwrDn_q;
  assign crystal_load_trim = trim_q;
  assign crystal_drive_strength = drive_q;

  sequence s_silentSecEdge;
    autoMode && secRise && !priEdge && lossCnt_q == 2'h1;
  endsequence

  property p_lossAfterTwo;
    @(posedge clk) disable iff (!reset_n)
      s_silentSecEdge |=> primaryLost_q;
  endproperty
  a_lossAfterTwo: assert property (p_lossAfterTwo)
    else $error("primary not declared lost after two silent secondary cycles");

  property p_noEarlyLoss;
    @(posedge clk) disable iff (!reset_n)
      (!primaryLost_q && lossCnt_q == 2'h0) |=> !primaryLost_q;
  endproperty
  a_noEarlyLoss: assert property (p_noEarlyLoss)
    else $error("primary declared lost before two secondary cycles");

  property p_revert;
    @(posedge clk) disable iff (!reset_n)
      (autoMode && priEdge) |=> !primaryLost_q;
  endproperty
  a_revert: assert property (p_revert)
    else $error("primary activity did not clear loss");

  property p_manualNoLoss;
    @(posedge clk) disable iff (!reset_n)
      !autoMode |=> !primaryLost_q;
  endproperty
  a_manualNoLoss: assert property (p_manualNoLoss)
    else $error("loss flagged in manual mode");

  property p_noGlitch;
    @(posedge clk) disable iff (!reset_n)
      state_q != rcs_pkg::ST_FOLLOW |=> !$rose(out_q);
  endproperty
  a_noGlitch: assert property (p_noGlitch)
    else $error("output rose during hand-over");

  property p_autoBackup;
    @(posedge clk) disable iff (!reset_n)
      (autoMode && primaryLost_q && state_q == rcs_pkg::ST_FOLLOW && curAux_q == targetAux)
        |-> curAux_q == !primarySel_q;
  endproperty
  a_autoBackup: assert property (p_autoBackup)
    else $error("lost primary but secondary not in use");

  property p_manualPick;
    @(posedge clk) disable iff (!reset_n)
      (!autoMode && state_q == rcs_pkg::ST_FOLLOW && curAux_q == targetAux)
        |-> curAux_q == (primarySel_q ^ selS);
  endproperty
  a_manualPick: assert property (p_manualPick)
    else $error("manual selection not followed");

  property p_powerDown;
    @(posedge clk) disable iff (!reset_n)
      (div_q[0] == 7'h00) ##1 (div_q[0] == 7'h00) |-> loopPowerDown[0];
  endproperty
  a_powerDown: assert property (p_powerDown)
    else $error("loop0 not powered down at zero divider");

  property p_loop3Div;
    @(posedge clk) disable iff (!reset_n)
      $stable(div_q[3]) && div_q[3] < 7'h03 |=> err_q[3];
  endproperty
  a_loop3Div: assert property (p_loop3Div)
    else $error("loop3 low divider not flagged");

  property p_mult0;
    @(posedge clk) disable iff (!reset_n)
      (wrLoop0 && regWdata[27:24] == 4'h0) |=> ##1 mult_q[0] == {1'b0, $past(regWdata[19:8], 2), 1'b0};
  endproperty
  a_mult0: assert property (p_mult0)
    else $error("loop0 multiplier wrong with zero add");

  property p_loadCap;
    @(posedge clk) disable iff (!reset_n)
      wrXtal |=> ##1 loadCap_q == 6'h1C + {1'b0, $past(regWdata[4:0], 2)};
  endproperty
  a_loadCap: assert property (p_loadCap)
    else $error("load capacitance code wrong");

endmodule

// file: test/rcs_ref_source.sv
/*
  behavioural model of the two reference sources: an oscillator on the
  crystal-or-reference pin and an external clock on the auxiliary pin.
  assumes the bench gates each source with its run input.
*/
`timescale 1ns/1ps
module rcs_ref_source #(
  parameter int CRYSTAL_HALF_NS = 413,
  parameter int AUX_HALF_NS = 617
) (
  input wire logic runCrystal,
  input wire logic runAux,
  output logic crystalClk,
  output logic auxClk
);
  // an oscillator, not a crystal, so switchover and default trim apply
  initial crystalClk = 1'h0;
  initial auxClk = 1'h0;
  // secondary half period longer than the primary one
  always
  begin
    #(CRYSTAL_HALF_NS);
    crystalClk = runCrystal ? ~crystalClk : 1'h0;
  end
  // a stopped source reads low, as the aux pull-down would leave it
  always
  begin
    #(AUX_HALF_NS);
    auxClk = runAux ? ~auxClk : 1'h0;
  end
endmodule

// file: test/tb_top.sv
/*
  self-checking bench for the reference clock switchover block.
  assumes the source model rcs_ref_source drives both reference pins.
*/
`timescale 1ns/1ps
module tb_top;
  logic clk;
  logic reset_n;
  logic [7:0] regAddr;
  logic [31:0] regWdata;
  logic regWrite;
  logic regRead;
  logic [31:0] regRdata;
  logic crystalIn;
  logic auxIn;
  logic selPin;
  logic runCrystal;
  logic runAux;
  logic refClkOut;
  logic activeSecondary;
  logic [3:0] loopPowerDown;
  logic [4:0] trim;
  logic [1:0] drive;
  logic [31:0] rd;
  int rises;
  int bad_count;
  int comparisons;

  rcs_ref_clock_switchover i_rcs_ref_clock_switchover (
    .clk(clk),
    .reset_n(reset_n),
    .regAddr(regAddr),
    .regWdata(regWdata),
    .regWrite(regWrite),
    .regRead(regRead),
    .regRdata(regRdata),
    .crystal_or_ref_input(crystalIn),
    .aux_clock_input(auxIn),
    .input_select_pin(selPin),
    .refClkOut(refClkOut),
    .activeSecondary(activeSecondary),
    .loopPowerDown(loopPowerDown),
    .crystal_load_trim(trim),
    .crystal_drive_strength(drive)
  );

  rcs_ref_source i_rcs_ref_source (
    .runCrystal(runCrystal),
    .runAux(runAux),
    .crystalClk(crystalIn),
    .auxClk(auxIn)
  );

  initial
  begin
    clk = 1'h0;
    forever #25 clk = ~clk;
  end

  task automatic final_report();
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task automatic chkVal(input string what, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp)
    begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic regWr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    regAddr <= a;
    regWdata <= d;
    regWrite <= 1'h1;
    @(posedge clk);
    regWrite <= 1'h0;
  endtask

  task automatic regRd(input logic [7:0] a);
    @(posedge clk);
    regAddr <= a;
    regRead <= 1'h1;
    @(posedge clk);
    regRead <= 1'h0;
    #1;
    rd = regRdata;
  endtask

  // bounded wait on the selected source, then compare
  task automatic waitSec(input logic exp);
    int n;
    n = 0;
    // sample off the edge that launches the registered output
    @(posedge clk);
    #1;
    while (activeSecondary !== exp && n < 400)
    begin
      @(posedge clk);
      #1;
      n++;
    end
    chkVal("activeSecondary", {31'h0, exp}, {31'h0, activeSecondary});
    if (activeSecondary !== exp)
      final_report();
  endtask

  task automatic countRise(input int cyc);
    logic prev;
    rises = 0;
    prev = refClkOut;
    repeat (cyc)
    begin
      @(posedge clk);
      #1;
      if (refClkOut === 1'h1 && prev === 1'h0)
        rises++;
      prev = refClkOut;
    end
  endtask

  task automatic testReset();
    regRd(rcs_pkg::OFS_CTRL);
    chkVal("ctrl", 32'h0000_0000, rd);
    regRd(rcs_pkg::OFS_CRYSTAL_LOAD_TRIM);
    chkVal("crystal_load_trim", 32'h0000_0300, rd);
    regRd(rcs_pkg::OFS_LOOP0);
    chkVal("loop0", 32'h0000_1001, rd);
    regRd(rcs_pkg::OFS_LOADCAP);
    chkVal("loadcap", 32'h0000_001C, rd);
    regRd(8'h40);
    chkVal("unmapped", 32'h0000_0000, rd);
    chkVal("pins", 32'h0000_0006, {25'h0, loopPowerDown, drive, trim[0]});
    $display("test reset done");
  endtask

  task automatic testTrim();
    regWr(rcs_pkg::OFS_CRYSTAL_LOAD_TRIM, 32'h0000_021F);
    @(posedge clk);
    #1;
    chkVal("trim pins", 32'h0000_005F, {25'h0, drive, trim});
    regWr(rcs_pkg::OFS_LOADCAP, 32'h0000_0000);
    regRd(rcs_pkg::OFS_LOADCAP);
    chkVal("loadcap max", 32'h0000_003B, rd);
    regWr(rcs_pkg::OFS_CRYSTAL_LOAD_TRIM, 32'h0000_0300);
    $display("test trim done");
  endtask

  task automatic testLoops();
    for (int i = 0; i < 4; i++)
      regWr(rcs_pkg::OFS_LOOP0 + 8'(4 * i), 32'h0F0F_FF00);
    repeat (3) @(posedge clk);
    #1;
    chkVal("powerdown", 32'h0000_0007, {28'h0, loopPowerDown});
    regRd(rcs_pkg::OFS_STATUS);
    chkVal("status loops", 32'h0000_0087, {24'h0, rd[9:2]});
    regRd(rcs_pkg::OFS_MULT0);
    chkVal("mult0 max", 32'h0000_200E, rd);
    regRd(rcs_pkg::OFS_MULT0 + 8'h04);
    chkVal("mult1 max", 32'h0000_0FFF, rd);
    regWr(rcs_pkg::OFS_LOOP0, 32'h0000_0501);
    repeat (3) @(posedge clk);
    regRd(rcs_pkg::OFS_MULT0);
    chkVal("mult0 no add", 32'h0000_000A, rd);
    chkVal("powerdown", 32'h0000_0006, {28'h0, loopPowerDown});
    $display("test loops done");
  endtask

  // every mode code with the select pin high; the pin only counts in manual
  task automatic testModes();
    logic [2:0] m;
    @(posedge clk);
    selPin <= 1'h1;
    for (int k = 0; k < 4; k++)
    begin
      m = 3'(2 * k);
      regWr(rcs_pkg::OFS_CTRL, {29'h0, m});
      waitSec(~m[2]);
      regRd(rcs_pkg::OFS_STATUS);
      chkVal("auto flag", {31'h0, m[2]}, {31'h0, rd[10]});
    end
    $display("test modes done");
  endtask

  task automatic testManual();
    regWr(rcs_pkg::OFS_CTRL, 32'h0000_0000);
    selPin <= 1'h0;
    waitSec(1'h0);
    selPin <= 1'h1;
    waitSec(1'h1);
    runAux <= 1'h0;
    repeat (40) @(posedge clk);
    countRise(80);
    chkVal("rises aux stopped", 32'h0, 32'(rises));
    runAux <= 1'h1;
    countRise(120);
    chkVal("aux followed", 32'h1, {31'h0, rises > 0});
    runCrystal <= 1'h0;
    regWr(rcs_pkg::OFS_CTRL, 32'h0000_0001);
    repeat (40) @(posedge clk);
    countRise(80);
    chkVal("rises crystal stopped", 32'h0, 32'(rises));
    selPin <= 1'h0;
    waitSec(1'h0);
    runCrystal <= 1'h1;
    $display("test manual done");
  endtask

  // automatic mode only with the crystal-or-reference pin as primary
  task automatic testAuto();
    regWr(rcs_pkg::OFS_CTRL, 32'h0000_0004);
    waitSec(1'h0);
    runCrystal <= 1'h0;
    repeat (12) @(posedge clk);
    #1;
    chkVal("early switch", 32'h0, {31'h0, activeSecondary});
    waitSec(1'h1);
    regRd(rcs_pkg::OFS_STATUS);
    chkVal("lost", 32'h3, {30'h0, rd[1:0]});
    runCrystal <= 1'h1;
    waitSec(1'h0);
    $display("test auto done");
  endtask

  initial
  begin
    reset_n = 1'h0;
    regAddr = 8'h00;
    regWdata = 32'h0000_0000;
    regWrite = 1'h0;
    regRead = 1'h0;
    selPin = 1'h0;
    runCrystal = 1'h1;
    runAux = 1'h1;
    bad_count = 0;
    comparisons = 0;
    repeat (2) @(posedge clk);
    reset_n <= 1'h1;
    testReset();
    testTrim();
    testLoops();
    testModes();
    testManual();
    testAuto();
    final_report();
  end
endmodule
